// >>> logic/blc_pkg.sv
package blc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BITDIV = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_TEST = 8'h0c;
  localparam logic [7:0] OFS_RXDATA = 8'h10;
  localparam logic [7:0] OFS_TXDATA = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // Field positions
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int DATA_BIT = 0;
  localparam int CMD_W = 4;
  localparam int ST_RXFLAG_BIT = 0;
  localparam int ST_TXFLAG_BIT = 1;
  localparam int ST_RXRUN_BIT = 2;
  localparam int ST_QUAL_BIT = 3;
  localparam int ST_MODEM_BIT = 4;
  localparam int ST_AUX_BIT = 5;
  // Channel control command codes
  localparam logic [3:0] CMD_CLR_RX = 4'h1;
  localparam logic [3:0] CMD_CLR_TX = 4'h2;
  localparam logic [3:0] CMD_MODEM_OFF = 4'h3;
  localparam logic [3:0] CMD_MODEM_ON = 4'h4;
  localparam logic [3:0] CMD_STOP_RX = 4'h5;
  localparam logic [3:0] CMD_AUX_A = 4'h6;
  localparam logic [3:0] CMD_AUX_B = 4'h7;
  // Channel status test codes
  localparam logic [3:0] TST_RXFLAG = 4'h1;
  localparam logic [3:0] TST_TXFLAG = 4'h2;
  localparam logic [3:0] TST_DSR = 4'h5;
  localparam logic [3:0] TST_CARRIER_OFF = 4'h6;
  localparam logic [3:0] TST_SUP_RXD = 4'h8;
  localparam logic [3:0] TST_RXD = 4'h9;
  // Timing: default line rate and derived bit period in clock cycles
  localparam int CLK_HZ = 200_000_000;
  localparam int BIT_RATE_HZ = 110;
  localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_HZ;
  localparam int DIV_W = 24;
  localparam logic [DIV_W-1:0] DIV_MIN = 24'h000002;
  // Reset values
  localparam logic RST_TXBUF = 1'b1;
  localparam logic RST_LINE = 1'b1;
  localparam logic [3:0] RST_TEST = 4'h1;
  typedef enum logic [1:0] {
    BLC_RX_IDLE = 2'b00,
    BLC_RX_QUAL = 2'b01,
    BLC_RX_RUN = 2'b11
  } blc_rx_e;
endpackage

// >>> logic/blc_bit_line_channel.sv
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/10ps
// Behaviour
// - An idle line going to space starts the receive bit clock.
// - Space must last half a bit time before the clock starts.
// - Running clock samples the line mid-bit, start bit included.
// - Each sample loads the receive buffer and sets the receive flag.
// - Sampling repeats every bit time until software stops it.
// - Reading the received bit clears receive flag and buffer.
// - After stop, flag stays clear until a new valid start space.
// - Command 1 clears receive flag/buffer; command 2 clears transmit flag/buffer.
// - Commands 3 and 4 drop and raise the modem control output.
// - First variant: commands 6/7 set/clear echo; 8 and 0 do nothing.
// - Second variant: commands 6/7 raise/drop restraint or originate output.
// - Test 1 receive flag, 2 transmit flag, 9 line on first variant.
// - Second variant: test 5 DSR, 6 carrier off, 8 supervisory, 9 data.
// - Transmit flag set on every transmit clock, once per bit.
// - Write loads bit into transmit buffer and clears transmit flag.
// - Every transmit clock drives the buffer bit onto the line, except while echo is on in the first variant.
module blc_bit_line_channel #(
  parameter int BIT_CYCLES = blc_pkg::BIT_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic rxd_i,
  input wire logic dsr_i,
  input wire logic carrier_off_i,
  input wire logic sup_rxd_i,
  output logic txd_o,
  output logic modem_ctl_o,
  output logic aux_ctl_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [blc_pkg::DIV_W-1:0] eff_div(input logic [blc_pkg::DIV_W-1:0] d);
    eff_div = (d < blc_pkg::DIV_MIN) ? blc_pkg::DIV_MIN : d;
  endfunction

  function automatic logic test_sel(input logic [3:0] code, input logic var_b,
                                    input logic rxf, input logic txf, input logic rxd,
                                    input logic dsr, input logic coff, input logic sup);
    test_sel = 1'b0;
    case (code)
      blc_pkg::TST_RXFLAG: test_sel = rxf;
      blc_pkg::TST_TXFLAG: test_sel = txf;
      blc_pkg::TST_RXD: test_sel = rxd;
      blc_pkg::TST_DSR: test_sel = var_b & dsr;
      blc_pkg::TST_CARRIER_OFF: test_sel = var_b & coff;
      blc_pkg::TST_SUP_RXD: test_sel = var_b & sup;
      default: test_sel = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic ce;
  logic acc;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic var_b_q;
  logic [blc_pkg::DIV_W-1:0] bitdiv_q;
  logic [3:0] test_q;
  logic echo_q;
  logic rx_flag_q;
  logic rx_buf_q;
  logic tx_flag_q;
  logic tx_buf_q;
  logic [blc_pkg::DIV_W-1:0] rx_cnt_q;
  logic [blc_pkg::DIV_W-1:0] tx_cnt_q;
  blc_pkg::blc_rx_e rx_st_q;
  logic wr_apply;
  logic cmd_go;
  logic [3:0] cmd;
  logic rx_read;
  logic rx_tick;
  logic tx_tick;
  logic tx_write;
  logic [blc_pkg::DIV_W-1:0] div;

  assign ce = ce_i;
  assign acc = ce & hsel_i & htrans_i[1] & hready_i;
  assign wr_apply = ce & wr_pend_q;
  assign cmd_go = wr_apply & (wr_addr_q == blc_pkg::OFS_CMD);
  assign cmd = hwdata_i[blc_pkg::CMD_W-1:0];
  assign tx_write = wr_apply & (wr_addr_q == blc_pkg::OFS_TXDATA);
  // Side effect of the read is taken in the address phase
  assign rx_read = acc & ~hwrite_i & (haddr_i[7:0] == blc_pkg::OFS_RXDATA);
  assign div = eff_div(bitdiv_q);
  // Start bit sampled once the space has held half a bit time
  assign rx_tick = ce & (rx_cnt_q == '0) & ((rx_st_q == blc_pkg::BLC_RX_RUN) |
                   ((rx_st_q == blc_pkg::BLC_RX_QUAL) & ~rxd_i));
  assign tx_tick = ce & (tx_cnt_q == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else if (ce) begin
      wr_pend_q <= acc & hwrite_i;
      if (acc) begin
        wr_addr_q <= haddr_i[7:0];
      end
      if (acc & ~hwrite_i) begin
        hrdata_o <= 32'h0000_0000;
        case (haddr_i[7:0])
          blc_pkg::OFS_CTRL: hrdata_o[blc_pkg::CTRL_VARIANT_BIT] <= var_b_q;
          blc_pkg::OFS_BITDIV: hrdata_o[blc_pkg::DIV_W-1:0] <= bitdiv_q;
          blc_pkg::OFS_TEST: hrdata_o[blc_pkg::DATA_BIT] <= test_sel(test_q, var_b_q,
              rx_flag_q, tx_flag_q, rxd_i, dsr_i, carrier_off_i, sup_rxd_i);
          blc_pkg::OFS_RXDATA: hrdata_o[blc_pkg::DATA_BIT] <= rx_buf_q;
          blc_pkg::OFS_TXDATA: hrdata_o[blc_pkg::DATA_BIT] <= tx_buf_q;
          blc_pkg::OFS_STATUS: begin
            hrdata_o[blc_pkg::ST_RXFLAG_BIT] <= rx_flag_q;
            hrdata_o[blc_pkg::ST_TXFLAG_BIT] <= tx_flag_q;
            hrdata_o[blc_pkg::ST_RXRUN_BIT] <= (rx_st_q == blc_pkg::BLC_RX_RUN);
            hrdata_o[blc_pkg::ST_QUAL_BIT] <= (rx_st_q == blc_pkg::BLC_RX_QUAL);
            hrdata_o[blc_pkg::ST_MODEM_BIT] <= modem_ctl_o;
            hrdata_o[blc_pkg::ST_AUX_BIT] <= var_b_q ? aux_ctl_o : echo_q;
          end
          default: hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      var_b_q <= 1'b0;
      bitdiv_q <= blc_pkg::DIV_W'(BIT_CYCLES);
      test_q <= blc_pkg::RST_TEST;
    end else if (wr_apply) begin
      case (wr_addr_q)
        blc_pkg::OFS_CTRL: var_b_q <= hwdata_i[blc_pkg::CTRL_VARIANT_BIT];
        blc_pkg::OFS_BITDIV: bitdiv_q <= hwdata_i[blc_pkg::DIV_W-1:0];
        blc_pkg::OFS_TEST: test_q <= hwdata_i[3:0];
        default: test_q <= test_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem control, echo and auxiliary outputs; 0 and 8 fall through
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      modem_ctl_o <= 1'b0;
      echo_q <= 1'b0;
      aux_ctl_o <= 1'b0;
    end else if (cmd_go) begin
      case (cmd)
        blc_pkg::CMD_MODEM_OFF: modem_ctl_o <= 1'b0;
        blc_pkg::CMD_MODEM_ON: modem_ctl_o <= 1'b1;
        blc_pkg::CMD_AUX_A: begin
          if (var_b_q) aux_ctl_o <= 1'b1;
          else echo_q <= 1'b1;
        end
        blc_pkg::CMD_AUX_B: begin
          if (var_b_q) aux_ctl_o <= 1'b0;
          else echo_q <= 1'b0;
        end
        default: echo_q <= echo_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive bit clock
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_st_q <= blc_pkg::BLC_RX_IDLE;
      rx_cnt_q <= '0;
    end else if (ce) begin
      if (cmd_go && cmd == blc_pkg::CMD_STOP_RX) begin
        rx_st_q <= blc_pkg::BLC_RX_IDLE;
      end else begin
        case (rx_st_q)
          blc_pkg::BLC_RX_IDLE: begin
            if (!rxd_i) begin
              rx_st_q <= blc_pkg::BLC_RX_QUAL;
              rx_cnt_q <= (div >> 1) - 1'b1;
            end
          end
          blc_pkg::BLC_RX_QUAL: begin
            if (rxd_i) begin
              rx_st_q <= blc_pkg::BLC_RX_IDLE;
            end else if (rx_tick) begin
              rx_st_q <= blc_pkg::BLC_RX_RUN;
              rx_cnt_q <= div - 1'b1;
            end else begin
              rx_cnt_q <= rx_cnt_q - 1'b1;
            end
          end
          blc_pkg::BLC_RX_RUN: begin
            // No character length here: runs until told to stop
            rx_cnt_q <= rx_tick ? div - 1'b1 : rx_cnt_q - 1'b1;
          end
          default: rx_st_q <= blc_pkg::BLC_RX_IDLE;
        endcase
      end
    end
  end

  // Receive flag and buffer: a sample wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_flag_q <= 1'b0;
      rx_buf_q <= 1'b0;
    end else if (ce) begin
      if (rx_tick) begin
        rx_flag_q <= 1'b1;
        rx_buf_q <= rxd_i;
      end else if (rx_read || (cmd_go && cmd == blc_pkg::CMD_CLR_RX)) begin
        rx_flag_q <= 1'b0;
        rx_buf_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit clock runs free, independent of receive
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_cnt_q <= '0;
    end else if (ce) begin
      tx_cnt_q <= tx_tick ? div - 1'b1 : tx_cnt_q - 1'b1;
    end
  end

  // Write and clock in the same cycle: the new bit is taken, the flag is set
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_flag_q <= 1'b0;
      tx_buf_q <= blc_pkg::RST_TXBUF;
    end else if (ce) begin
      if (tx_write) begin
        tx_buf_q <= hwdata_i[blc_pkg::DATA_BIT];
      end else if (cmd_go && cmd == blc_pkg::CMD_CLR_TX) begin
        tx_buf_q <= 1'b0;
      end
      if (tx_tick) begin
        tx_flag_q <= 1'b1;
      end else if (tx_write || (cmd_go && cmd == blc_pkg::CMD_CLR_TX)) begin
        tx_flag_q <= 1'b0;
      end
    end
  end

  // Line driver; echo mode loops the receive line straight back
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txd_o <= blc_pkg::RST_LINE;
    end else if (ce) begin
      if (echo_q && !var_b_q) begin
        txd_o <= rxd_i;
      end else if (tx_tick) begin
        txd_o <= tx_buf_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  rx_start_a: assert property (rx_st_q == blc_pkg::BLC_RX_IDLE && ce && !rxd_i && !cmd_go
    |=> rx_st_q == blc_pkg::BLC_RX_QUAL) else $error("start space ignored");
  noise_reject_a: assert property (rx_st_q == blc_pkg::BLC_RX_QUAL && ce && rxd_i && !cmd_go
    |=> rx_st_q == blc_pkg::BLC_RX_IDLE && !$rose(rx_flag_q)) else $error("noise started");
  qual_hold_a: assert property ($rose(rx_st_q == blc_pkg::BLC_RX_RUN)
    |-> $past(rx_st_q == blc_pkg::BLC_RX_QUAL) && $past(rx_cnt_q == '0))
    else $error("clock started early");
  rx_sample_a: assert property (rx_tick |=> rx_flag_q && rx_buf_q == $past(rxd_i))
    else $error("sample not loaded");
  rx_take_a: assert property (rx_read && !rx_tick |=> !rx_flag_q && !rx_buf_q)
    else $error("read did not clear");
  rx_stop_a: assert property (cmd_go && cmd == blc_pkg::CMD_STOP_RX
    |=> rx_st_q == blc_pkg::BLC_RX_IDLE) else $error("stop ignored");
  idle_clear_a: assert property (rx_st_q == blc_pkg::BLC_RX_IDLE && !rx_flag_q
    |=> !rx_flag_q) else $error("flag set while stopped");
  tx_clock_a: assert property (tx_tick && !(echo_q && !var_b_q)
    |=> tx_flag_q && txd_o == $past(tx_buf_q)) else $error("transmit clock lost");
  tx_load_a: assert property (tx_write && !tx_tick
    |=> !tx_flag_q && tx_buf_q == $past(hwdata_i[0])) else $error("bit not loaded");
  modem_cmd_a: assert property (cmd_go && cmd == blc_pkg::CMD_MODEM_ON
    |=> modem_ctl_o) else $error("modem output not raised");

  char_rx_c: cover property (rx_tick ##[1:300] rx_read);
  noise_c: cover property (rx_st_q == blc_pkg::BLC_RX_QUAL ##1 rx_st_q == blc_pkg::BLC_RX_IDLE);
  tx_c: cover property (tx_write ##[1:300] tx_tick);
  echo_c: cover property (echo_q && !var_b_q && $fell(txd_o));

endmodule // blc_bit_line_channel

// >>> tb/blc_line_model.sv
`timescale 1ns/10ps
// Far end of the line: a start-stop terminal whose line idles at mark
module blc_line_model #(
  parameter int BIT = 24
) (
  input wire logic clk_i,
  output logic rxd_o,
  output logic dsr_o,
  output logic carrier_off_o,
  output logic sup_rxd_o
);
  initial begin
    rxd_o = 1'b1;
    dsr_o = 1'b0;
    carrier_off_o = 1'b1;
    sup_rxd_o = 1'b1;
  end
  // Each bit stands a full bit time, start bit first; line falls back to mark
  task automatic send(input logic [7:0] bits);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      rxd_o <= bits[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask
  // Short space, as line noise would make
  task automatic glitch(input int len);
    @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (len) @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask
  task automatic levels(input logic dsr, input logic coff, input logic sup);
    @(posedge clk_i);
    dsr_o <= dsr;
    carrier_off_o <= coff;
    sup_rxd_o <= sup;
  endtask
endmodule // blc_line_model

// >>> tb/blc_bit_line_channel_tb_top.sv
`timescale 1ns/10ps
module blc_bit_line_channel_tb_top;
  // Short bit time keeps the run brief; margins still leave room for polling
  localparam int BITC = 24;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, rxd, dsr, coff, sup, txd, modem, aux;
  logic [31:0] rd;
  int n_fail = 0;
  int checks = 0;

  always #2.5 clk = ~clk;

  blc_bit_line_channel #(.BIT_CYCLES(BITC)) u_blc_bit_line_channel (
    .clk_sys_i(clk), .resetn_i(resetn), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .rxd_i(rxd), .dsr_i(dsr), .carrier_off_i(coff), .sup_rxd_i(sup), .txd_o(txd),
    .modem_ctl_o(modem), .aux_ctl_o(aux));

  blc_line_model #(.BIT(BITC)) u_blc_line_model (
    .clk_i(clk), .rxd_o(rxd), .dsr_o(dsr), .carrier_off_o(coff), .sup_rxd_o(sup));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t %s got=%h exp=%h", $time, what, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    #1;
  endtask

  task automatic rdw(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input logic [3:0] c);
    xfer(1'b1, blc_pkg::OFS_CMD, {28'h0, c});
  endtask

  // Bounded poll of one status bit; leaves the status word in rd
  task automatic wait_st(input int b);
    for (int k = 0; k < 40; k++) begin
      rdw(blc_pkg::OFS_STATUS);
      if (rd[b] === 1'b1) break;
    end
    chk({31'h0, rd[b]}, 32'h1, "flag poll");
  endtask

  task automatic finish_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({29'h0, txd, modem, aux}, 32'h4, "reset pins");
    chk({31'h0, hresp}, 32'h0, "okay resp");
    rdw(blc_pkg::OFS_BITDIV);
    chk(rd, BITC, "bit divider");
    rdw(blc_pkg::OFS_STATUS);
    chk(rd, 32'h2, "status after reset");
    $display("test reset done");
  endtask

  task automatic t_rx();
    logic [7:0] ch;
    ch = 8'hda;
    u_blc_line_model.glitch(BITC / 2 - 3);
    repeat (2 * BITC) @(posedge clk);
    rdw(blc_pkg::OFS_STATUS);
    chk(rd & 32'h5, 32'h0, "noise ignored");
    fork
      u_blc_line_model.send(ch);
      for (int i = 0; i < 8; i++) begin
        wait_st(blc_pkg::ST_RXFLAG_BIT);
        if (i == 3) begin
          cmd(blc_pkg::CMD_CLR_RX);
          rdw(blc_pkg::OFS_RXDATA);
          chk(rd, 32'h0, "cleared bit");
        end else begin
          rdw(blc_pkg::OFS_RXDATA);
          chk(rd, {31'h0, ch[i]}, "rx bit");
        end
        rdw(blc_pkg::OFS_STATUS);
        chk({29'h0, rd[2:0]}, 32'h6, "flags after take");
      end
    join
    cmd(blc_pkg::CMD_STOP_RX);
    repeat (3 * BITC) @(posedge clk);
    rdw(blc_pkg::OFS_STATUS);
    chk({29'h0, rd[2:0]}, 32'h2, "stopped");
    $display("test rx done");
  endtask

  task automatic t_tx();
    logic [7:0] pat;
    pat = 8'hd6;
    // Clearing the flag first lines the loop up with a fresh transmit clock
    xfer(1'b1, blc_pkg::OFS_TXDATA, 32'h1);
    for (int i = 0; i < 9; i++) begin
      wait_st(blc_pkg::ST_TXFLAG_BIT);
      if (i > 0) chk({31'h0, txd}, {31'h0, pat[i-1]}, "line bit");
      if (i < 8) begin
        xfer(1'b1, blc_pkg::OFS_TXDATA, {31'h0, pat[i]});
        rdw(blc_pkg::OFS_STATUS);
        chk({30'h0, rd[1:0]}, 32'h0, "tx flag cleared");
      end
    end
    repeat (3 * BITC) @(posedge clk);
    chk({31'h0, txd}, 32'h1, "mark repeats");
    // Clear just after a transmit clock so none falls before the status read
    xfer(1'b1, blc_pkg::OFS_TXDATA, 32'h1);
    wait_st(blc_pkg::ST_TXFLAG_BIT);
    cmd(blc_pkg::CMD_CLR_TX);
    rdw(blc_pkg::OFS_STATUS);
    chk({31'h0, rd[1]}, 32'h0, "tx flag reset");
    rdw(blc_pkg::OFS_TXDATA);
    chk(rd, 32'h0, "tx buffer reset");
    xfer(1'b1, blc_pkg::OFS_TXDATA, 32'h1);
    $display("test tx done");
  endtask

  task automatic t_cmd();
    logic [23:0] cv;
    logic [11:0] ev;
    cv = 24'h468037;
    ev = 12'h7f8;
    xfer(1'b1, blc_pkg::OFS_CTRL, 32'h0);
    for (int i = 0; i < 6; i++) begin
      cmd(cv[23-4*i -: 4]);
      rdw(blc_pkg::OFS_STATUS);
      chk({30'h0, rd[5:4]}, {30'h0, ev[11-2*i -: 2]}, "first variant cmd");
      chk({31'h0, modem}, {31'h0, ev[10-2*i]}, "modem pin");
      if (i == 1) begin
        // Echo on: a short space on the receive line shows on the transmit line
        u_blc_line_model.glitch(4);
        #1;
        chk({31'h0, txd}, 32'h0, "echo space");
      end
    end
    xfer(1'b1, blc_pkg::OFS_CTRL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      cmd(i == 0 ? blc_pkg::CMD_AUX_A : blc_pkg::CMD_AUX_B);
      chk({31'h0, aux}, {31'h0, i == 0}, "aux pin");
    end
    $display("test cmd done");
  endtask

  task automatic t_tst();
    logic [11:0] cv;
    logic [15:0] c0;
    cv = 12'h568;
    c0 = 16'h1293;
    for (int p = 0; p < 2; p++) begin
      u_blc_line_model.levels(p == 0, p == 1, p == 0);
      for (int k = 0; k < 3; k++) begin
        xfer(1'b1, blc_pkg::OFS_TEST, {28'h0, cv[11-4*k -: 4]});
        rdw(blc_pkg::OFS_TEST);
        chk(rd, {31'h0, (k == 1) ? p == 1 : p == 0}, "second variant test");
      end
    end
    xfer(1'b1, blc_pkg::OFS_CTRL, 32'h0);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, blc_pkg::OFS_TEST, {28'h0, c0[15-4*k -: 4]});
      rdw(blc_pkg::OFS_TEST);
      chk(rd, {31'h0, k == 1 || k == 2}, "first variant test");
    end
    $display("test tst done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_rx();
    t_tx();
    t_cmd();
    t_tst();
    finish_test();
  end

  // The whole sequence needs under a thousand cycles; twenty times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    finish_test();
  end
endmodule // blc_bit_line_channel_tb_top
